// >>> rtl/delta_stat_encoder.sv
// Statistical delta encoder: quantize, delta code, serialise, pack 30-bit words
`timescale 1ns/1ps
`default_nettype none

module delta_stat_encoder #(
   parameter logic [29:0] TIME_CODE  = delta_stat_pkg::TIME_CODE_DEF,
   parameter logic [7:0]  VSYNC_CODE = delta_stat_pkg::VSYNC_CODE_DEF,
   parameter logic [7:0]  HSYNC_CODE = delta_stat_pkg::HSYNC_CODE_DEF
) (
   input  wire logic        clk_sys,           // 200 MHz clock
   input  wire logic        reset,             // Synchronous reset
   input  wire logic [7:0]  address,           // Register byte address
   input  wire logic [31:0] wr_data,           // Register write data
   input  wire logic        wr_en,             // Write strobe
   input  wire logic        rd_en,             // Read strobe
   output logic      [31:0] rd_data,           // Read data, cycle after strobe
   input  wire logic        sample_strobe,     // External sample rate strobe
   input  wire logic [5:0]  video_in,          // Video sample
   input  wire logic        hblank,            // Horizontal blanking
   input  wire logic        vblank,            // Vertical blanking
   input  wire logic        nearly_empty,      // Transmit memory nearly empty
   input  wire logic [7:0]  fill_rate,         // Buffer fill rate count
   input  wire logic [29:0] reducer_path_data, // Reducer word
   input  wire logic        reducer_path_req,  // Reducer write request
   input  wire logic        mem_wr_ack,        // Memory control took the word
   output logic      [29:0] mem_data,          // Word to memory
   output logic             mem_wr_req,        // Write request to memory
   output logic      [2:0]  quant_level        // Current quantization level
);
   typedef delta_stat_pkg::code_ent_t ent_t;

   function automatic logic [5:0] quantize(input logic [5:0] v, input logic [2:0] ql);
      case (ql)
         delta_stat_pkg::QL5: quantize = {1'b1, v[5:1]};
         delta_stat_pkg::QL4: quantize = {2'b11, v[5:2]};
         default:             quantize = v;
      endcase
   endfunction

   // Delta codes fit up to three, otherwise remainder
   function automatic delta_stat_pkg::code_type_t code_sel(input logic [5:0] mag, input logic neg,
                                                          input logic force_rem);
      if (force_rem || mag > 6'h03)
         code_sel = delta_stat_pkg::CT_REM;
      else if (mag == 6'h00)
         code_sel = delta_stat_pkg::CT_D0;
      else if (neg)
         code_sel = delta_stat_pkg::code_type_t'(3'(mag) + 3'h3);
      else
         code_sel = delta_stat_pkg::code_type_t'(3'(mag));
   endfunction

   // Enables and strobe sequencing
   logic [1:0] div4_r;
   logic [3:0] div10_r;
   logic       int_strobe_r;
   logic       sync1_r, sync2_r;
   logic [2:0] strb_sh_r;
   logic       xfer_d_r;
   logic       ce50, xfer_p, load_p, shift_p;
   // Register file
   logic       stat_mode_r, int_rate_r;
   logic [7:0] thr_lo_r, thr_hi_r;
   ent_t [7:0] code_tab_r;
   logic [31:0] rd_data_r;
   // Data path
   logic       hb_s_r, vb_s_r, blank;
   logic [2:0] ql_r;
   logic [5:0] cur_r, prev_r;
   logic [6:0] diff;
   logic [5:0] mag;
   logic       neg;
   delta_stat_pkg::code_type_t ct_r;
   logic [2:0] code_len_r;
   logic [7:0] code_word_r;
   logic [2:0] hdr_idx_r;
   logic       hdr_vert_r;
   logic [7:0] len_sh_r, code_sh_r;
   logic       busy_r;
   logic [30:0] out_sh_r;
   logic [29:0] stat_buf_r;
   logic       buf_load_r, stat_req_r;
   logic [29:0] mem_data_r;
   logic       mem_wr_req_r;
   logic [2:0] h_len;
   logic [7:0] h_word;

   assign ce50    = div4_r == 2'(delta_stat_pkg::SHIFT_DIV - 1);
   assign xfer_p  = ce50 && strb_sh_r[1] && !strb_sh_r[2];
   assign blank   = hb_s_r || vb_s_r;
   assign load_p  = ce50 && xfer_d_r && !blank;
   assign shift_p = ce50 && busy_r && !load_p;
   assign diff    = {1'b0, cur_r} - {1'b0, prev_r};
   assign neg     = diff[6];
   assign mag     = neg ? 6'(-diff) : diff[5:0];

   always_ff @(posedge clk_sys) begin
      if (reset || ce50)
         div4_r <= 2'h0;
      else
         div4_r <= div4_r + 2'h1;
   end

   // Internal 5 MHz strobe, high for one shift tick
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div10_r      <= 4'h0;
         int_strobe_r <= 1'b0;
      end else if (ce50) begin
         div10_r      <= (div10_r == 4'(delta_stat_pkg::INT_DIV - 1)) ? 4'h0 : div10_r + 4'h1;
         int_strobe_r <= div10_r == 4'(delta_stat_pkg::INT_DIV - 1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync1_r   <= 1'b0;
         sync2_r   <= 1'b0;
         strb_sh_r <= 3'h0;
         xfer_d_r  <= 1'b0;
      end else begin
         sync1_r <= int_rate_r ? int_strobe_r : sample_strobe;
         sync2_r <= sync1_r;
         if (ce50) begin
            strb_sh_r <= {strb_sh_r[1:0], sync2_r};
            xfer_d_r  <= xfer_p;
         end
      end
   end

   // Register writes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stat_mode_r <= 1'b1;
         int_rate_r  <= 1'b0;
         thr_lo_r    <= delta_stat_pkg::THR_LO_RST;
         thr_hi_r    <= delta_stat_pkg::THR_HI_RST;
         code_tab_r  <= delta_stat_pkg::CODE_TAB_RST;
      end else if (wr_en) begin
         if (address == delta_stat_pkg::OFS_CTRL) begin
            stat_mode_r <= wr_data[delta_stat_pkg::CTRL_STAT_MODE];
            int_rate_r  <= wr_data[delta_stat_pkg::CTRL_INT_RATE];
         end
         if (address == delta_stat_pkg::OFS_THRESH) begin
            thr_lo_r <= wr_data[delta_stat_pkg::THR_LO_POS +: 8];
            thr_hi_r <= wr_data[delta_stat_pkg::THR_HI_POS +: 8];
         end
         if (address[7:5] == delta_stat_pkg::OFS_CODE[7:5] && address[1:0] == 2'h0)
            code_tab_r[address[4:2]] <= wr_data[10:0];
      end
   end

   // Register reads, unmapped reads zero
   always_ff @(posedge clk_sys) begin
      if (reset)
         rd_data_r <= 32'h0;
      else if (rd_en) begin
         if (address == delta_stat_pkg::OFS_CTRL)
            rd_data_r <= {30'h0, int_rate_r, stat_mode_r};
         else if (address == delta_stat_pkg::OFS_STATUS)
            rd_data_r <= {24'h0, stat_req_r, busy_r, hdr_idx_r != delta_stat_pkg::HDR_DONE, blank, 1'b0, ql_r};
         else if (address == delta_stat_pkg::OFS_THRESH)
            rd_data_r <= {16'h0, thr_hi_r, thr_lo_r};
         else if (address[7:5] == delta_stat_pkg::OFS_CODE[7:5] && address[1:0] == 2'h0)
            rd_data_r <= {21'h0, code_tab_r[address[4:2]]};
         else
            rd_data_r <= 32'h0;
      end else
         rd_data_r <= 32'h0;
   end

   // Blanking resync, line level choice, header sequencing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hb_s_r     <= 1'b0;
         vb_s_r     <= 1'b0;
         ql_r       <= delta_stat_pkg::QL6;
         hdr_idx_r  <= delta_stat_pkg::HDR_DONE;
         hdr_vert_r <= 1'b0;
      end else begin
         if (xfer_p) begin
            hb_s_r <= hblank;
            vb_s_r <= vblank;
            if (blank && !hblank && !vblank) begin
               hdr_vert_r <= vb_s_r;
               hdr_idx_r  <= vb_s_r ? 3'h0 : delta_stat_pkg::HDR_SYNC;
               if (fill_rate < thr_lo_r)
                  ql_r <= delta_stat_pkg::QL6;
               else if (fill_rate > thr_hi_r)
                  ql_r <= delta_stat_pkg::QL4;
               else
                  ql_r <= delta_stat_pkg::QL5;
            end
         end
         if (load_p && hdr_idx_r != delta_stat_pkg::HDR_DONE)
            hdr_idx_r <= hdr_idx_r + 3'h1;
      end
   end

   // Samples and code registers load on transfer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cur_r       <= 6'h00;
         prev_r      <= 6'h00;
         ct_r        <= delta_stat_pkg::CT_D0;
         code_len_r  <= 3'h0;
         code_word_r <= 8'h00;
      end else if (xfer_p) begin
         prev_r <= cur_r;
         cur_r  <= quantize(video_in, ql_r);
         ct_r   <= code_sel(mag, neg, nearly_empty);
         code_len_r  <= code_tab_r[code_sel(mag, neg, nearly_empty)].len_m1;
         if (code_sel(mag, neg, nearly_empty) == delta_stat_pkg::CT_REM)
            code_word_r <= {code_tab_r[delta_stat_pkg::CT_REM].pat[7:4], cur_r[5:2]};
         else
            code_word_r <= code_tab_r[code_sel(mag, neg, nearly_empty)].pat;
      end
   end

   // Start-of-line words: time code segments, sync, spare, absolute value
   always_comb begin
      h_len  = 3'h7;
      h_word = 8'h00;
      case (hdr_idx_r)
         3'h0: h_word = TIME_CODE[29:22];
         3'h1: h_word = TIME_CODE[21:14];
         3'h2: h_word = TIME_CODE[13:6];
         3'h3: begin
            h_word = {TIME_CODE[5:0], 2'b00};
            h_len  = 3'h5;
         end
         3'h4: h_word = hdr_vert_r ? VSYNC_CODE : HSYNC_CODE;
         3'h5: h_word = 8'h00;
         3'h6: h_word = {2'(ql_r - delta_stat_pkg::QL4), cur_r};
         default: h_word = 8'h00;
      endcase
   end

   // Length and code word shift registers, burst control
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         len_sh_r  <= 8'h00;
         code_sh_r <= 8'h00;
         busy_r    <= 1'b0;
      end else if (load_p) begin
         busy_r <= 1'b1;
         if (hdr_idx_r != delta_stat_pkg::HDR_DONE) begin
            len_sh_r  <= 8'h01 << h_len;
            code_sh_r <= h_word;
         end else begin
            len_sh_r  <= 8'h01 << code_len_r;
            code_sh_r <= code_word_r;
         end
      end else if (shift_p) begin
         len_sh_r  <= len_sh_r >> 1;
         code_sh_r <= code_sh_r << 1;
         if (len_sh_r[0])
            busy_r <= 1'b0;
      end
   end

   // Output packing with travelling tag bit
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_sh_r   <= delta_stat_pkg::OUT_SEED;
         stat_buf_r <= 30'h0;
         buf_load_r <= 1'b0;
      end else begin
         buf_load_r <= 1'b0;
         if (shift_p) begin
            if (out_sh_r[29]) begin
               stat_buf_r <= {out_sh_r[28:0], code_sh_r[7]};
               out_sh_r   <= delta_stat_pkg::OUT_SEED;
               buf_load_r <= 1'b1;
            end else
               out_sh_r <= {out_sh_r[29:0], code_sh_r[7]};
         end
      end
   end

   // Write request: a new word wins over a same-cycle acknowledge
   always_ff @(posedge clk_sys) begin
      if (reset)
         stat_req_r <= 1'b0;
      else if (buf_load_r)
         stat_req_r <= 1'b1;
      else if (mem_wr_ack && stat_mode_r)
         stat_req_r <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mem_data_r   <= 30'h0;
         mem_wr_req_r <= 1'b0;
      end else begin
         mem_data_r   <= stat_mode_r ? stat_buf_r : reducer_path_data;
         mem_wr_req_r <= stat_mode_r ? stat_req_r : reducer_path_req;
      end
   end

   assign rd_data     = rd_data_r;
   assign mem_data    = mem_data_r;
   assign mem_wr_req  = mem_wr_req_r;
   assign quant_level = ql_r;

   // Checks
   property p_seq;
      @(posedge clk_sys) disable iff (reset) xfer_p && !hblank && !vblank |-> ##4 load_p;
   endproperty
   a_seq: assert property (p_seq) else $error("load did not follow transfer");

   property p_blank;
      @(posedge clk_sys) disable iff (reset) blank |-> !load_p;
   endproperty
   a_blank: assert property (p_blank) else $error("load during blanking");

   property p_onehot;
      @(posedge clk_sys) disable iff (reset) load_p |=> $onehot(len_sh_r) && busy_r;
   endproperty
   a_onehot: assert property (p_onehot) else $error("length register not one-hot");

   property p_burst_end;
      @(posedge clk_sys) disable iff (reset) shift_p && len_sh_r[0] |=> !busy_r;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst overran");

   property p_burst_len;
      @(posedge clk_sys) disable iff (reset) load_p |-> ##1 busy_r [*4] ##[1:29] !busy_r;
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

   property p_rem;
      @(posedge clk_sys) disable iff (reset) xfer_p && nearly_empty |=> ct_r == delta_stat_pkg::CT_REM;
   endproperty
   a_rem: assert property (p_rem) else $error("remainder not forced");

   property p_pair;
      @(posedge clk_sys) disable iff (reset) xfer_p |=> prev_r == $past(cur_r);
   endproperty
   a_pair: assert property (p_pair) else $error("sample pair did not advance");

   property p_tag;
      @(posedge clk_sys) disable iff (reset) buf_load_r |-> out_sh_r == delta_stat_pkg::OUT_SEED ##1 stat_req_r;
   endproperty
   a_tag: assert property (p_tag) else $error("word end handling wrong");

   property p_sel;
      @(posedge clk_sys) disable iff (reset) stat_mode_r && $stable(stat_mode_r) |-> mem_data_r == $past(stat_buf_r);
   endproperty
   a_sel: assert property (p_sel) else $error("memory selector wrong");

   c_word:  cover property (@(posedge clk_sys) disable iff (reset) buf_load_r);
   c_rem:   cover property (@(posedge clk_sys) disable iff (reset) xfer_p && nearly_empty);
   c_vhdr:  cover property (@(posedge clk_sys) disable iff (reset) load_p && hdr_idx_r == 3'h3);
   c_ack:   cover property (@(posedge clk_sys) disable iff (reset) stat_req_r && mem_wr_ack);
endmodule

`default_nettype wire

// >>> rtl/delta_stat_pkg.sv
// Constants and types shared by the statistical delta encoder
package delta_stat_pkg;
   localparam int CLK_MHZ   = 200;
   localparam int SHIFT_MHZ = 50;
   localparam int SHIFT_DIV = CLK_MHZ / SHIFT_MHZ;
   localparam int INT_DIV   = 10;

   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_THRESH = 8'h08;
   localparam logic [7:0] OFS_CODE   = 8'h20;

   localparam int CTRL_STAT_MODE = 0;
   localparam int CTRL_INT_RATE  = 1;
   localparam int THR_LO_POS     = 0;
   localparam int THR_HI_POS     = 8;

   localparam logic [2:0] QL4 = 3'h4;
   localparam logic [2:0] QL5 = 3'h5;
   localparam logic [2:0] QL6 = 3'h6;
   localparam logic [7:0] THR_LO_RST = 8'h70;
   localparam logic [7:0] THR_HI_RST = 8'h90;

   localparam logic [2:0]  HDR_SYNC = 3'h4;
   localparam logic [2:0]  HDR_DONE = 3'h7;
   localparam logic [29:0] TIME_CODE_DEF = 30'h0104_0401;
   localparam logic [7:0]  VSYNC_CODE_DEF = 8'hF0;
   localparam logic [7:0]  HSYNC_CODE_DEF = 8'hCC;
   localparam logic [30:0] OUT_SEED = 31'h0000_0001;

   typedef enum logic [2:0] {CT_D0, CT_P1, CT_P2, CT_P3, CT_M1, CT_M2, CT_M3, CT_REM} code_type_t;

   typedef struct packed {
      logic [2:0] len_m1;
      logic [7:0] pat;
   } code_ent_t;

   localparam code_ent_t [7:0] CODE_TAB_RST = '{
      '{3'h7, 8'hF0}, '{3'h4, 8'hE8}, '{3'h3, 8'hD0}, '{3'h2, 8'hA0},
      '{3'h4, 8'hE0}, '{3'h3, 8'hC0}, '{3'h2, 8'h80}, '{3'h0, 8'h00}};
endpackage

// >>> sim/tx_mem_model.sv
// Memory control partner: acknowledges encoder writes and tracks the stored word count
`timescale 1ns/1ps
`default_nettype none
module tx_mem_model (
   input  wire logic        clk_sys,      // Clock
   input  wire logic        reset,        // Synchronous reset
   input  wire logic        mem_wr_req,   // Write request
   input  wire logic [29:0] mem_data,     // Word offered
   input  wire logic        slow,         // Answer late
   input  wire logic        drain,        // Remove one word a cycle
   input  wire logic        refill,       // Add one word a cycle
   output logic             mem_wr_ack,   // Write taken
   output logic             nearly_empty, // Four words or fewer left
   output logic             got_word,     // Word captured
   output logic      [29:0] got_data      // Captured word
);
   int   lvl_r;
   int   wait_r;
   logic take;
   logic done_r;

   // Ack once per request; the registered request stays up one cycle past the ack
   assign take = mem_wr_req && !mem_wr_ack && !done_r && wait_r == 0;
   assign nearly_empty = lvl_r <= 4;

   always_ff @(posedge clk_sys) begin
      mem_wr_ack <= take && !reset;
      got_word <= take && !reset;
      if (take)
         got_data <= mem_data;
      if (reset) begin
         lvl_r <= 16;
         wait_r <= 0;
         done_r <= 1'b0;
      end else begin
         if (take)
            done_r <= 1'b1;
         else if (!mem_wr_req)
            done_r <= 1'b0;
         wait_r <= !mem_wr_req ? (slow ? int'($urandom_range(6, 1)) : 0) : (wait_r > 0 ? wait_r - 1 : 0);
         lvl_r <= lvl_r + int'(take) + int'(refill) - int'(drain && lvl_r > 0);
      end
   end
endmodule
`default_nettype wire

// >>> sim/delta_stat_encoder_tb.sv
// Self-checking bench for the statistical delta encoder
`timescale 1ns/1ps
`default_nettype none
module delta_stat_encoder_tb;
   logic        clk_sys, reset, wr_en, rd_en, sample_strobe, hblank, vblank;
   logic [7:0]  address, fill_rate;
   logic [31:0] wr_data, rd_data, rd_v;
   logic [5:0]  video_in, q_cur, q_prev, v;
   logic [29:0] reducer_path_data, mem_data, got_data, w;
   logic        reducer_path_req, mem_wr_ack, mem_wr_req, nearly_empty, got_word;
   logic        slow, drain, refill, ne_exp, blank_prev, vert_r, red_mode;
   logic [2:0]  quant_level, ql_exp;
   logic        exp_q[$];
   int          err_total, n_tests, hdr_idx, words_seen, n0;
   int          steps[16] = '{0, 1, 2, 3, -1, -2, -3, 4, -4, 0, 3, -3, 1, -1, 2, -2};

   delta_stat_encoder u_dut (.clk_sys(clk_sys), .reset(reset), .address(address), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sample_strobe(sample_strobe), .video_in(video_in),
      .hblank(hblank), .vblank(vblank), .nearly_empty(nearly_empty), .fill_rate(fill_rate),
      .reducer_path_data(reducer_path_data), .reducer_path_req(reducer_path_req), .mem_wr_ack(mem_wr_ack),
      .mem_data(mem_data), .mem_wr_req(mem_wr_req), .quant_level(quant_level));

   tx_mem_model u_mem (.clk_sys(clk_sys), .reset(reset), .mem_wr_req(mem_wr_req), .mem_data(mem_data),
      .slow(slow), .drain(drain), .refill(refill), .mem_wr_ack(mem_wr_ack), .nearly_empty(nearly_empty),
      .got_word(got_word), .got_data(got_data));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(negedge clk_sys);
      d = rd_data;
   endtask

   function automatic logic [5:0] quant(input logic [5:0] s, input logic [2:0] ql);
      if (ql == delta_stat_pkg::QL5)
         return {1'b1, s[5:1]};
      if (ql == delta_stat_pkg::QL4)
         return {2'b11, s[5:2]};
      return s;
   endfunction

   // Code table index from the registered difference
   function automatic int pick(input logic [5:0] c, input logic [5:0] p, input logic ne);
      int d;
      d = int'(c) - int'(p);
      if (ne)
         return 7;
      case (d)
         0, 1, 2, 3: return d;
         -1, -2, -3: return 3 - d;
         default: return 7;
      endcase
   endfunction

   task automatic push(input logic [29:0] val, input int n);
      for (int i = n - 1; i >= 0; i--)
         exp_q.push_back(val[i]);
   endtask

   task automatic push_code(input int t);
      delta_stat_pkg::code_ent_t e;
      logic [7:0]                pat;
      e = delta_stat_pkg::CODE_TAB_RST[t];
      pat = (t == 7) ? {e.pat[7:4], q_cur[5:2]} : e.pat;
      push(30'(pat >> (7 - e.len_m1)), int'(e.len_m1) + 1);
   endtask

   task automatic push_hdr(input int i);
      logic [29:0] tc;
      tc = delta_stat_pkg::TIME_CODE_DEF;
      case (i)
         0, 1, 2: push(tc >> (22 - 8 * i), 8);
         3: push(tc, 6);
         4: push(30'(vert_r ? delta_stat_pkg::VSYNC_CODE_DEF : delta_stat_pkg::HSYNC_CODE_DEF), 8);
         5: push(30'h0, 8);
         default: push(30'({2'(ql_exp - 3'h4), q_cur}), 8);
      endcase
   endtask

   // One sample period of 49 clocks; strobe high for 8 of them
   task automatic sample(input logic [5:0] s, input logic hb, input logic vb);
      @(posedge clk_sys);
      sample_strobe <= 1'b1;
      video_in <= s;
      hblank <= hb;
      vblank <= vb;
      if (hb || vb)
         vert_r = vb;
      else if (blank_prev) begin
         hdr_idx = vert_r ? 0 : 4;
         ql_exp = fill_rate < delta_stat_pkg::THR_LO_RST ? delta_stat_pkg::QL6 :
                  fill_rate > delta_stat_pkg::THR_HI_RST ? delta_stat_pkg::QL4 : delta_stat_pkg::QL5;
      end
      if (!(hb || vb)) begin
         if (hdr_idx < 7) begin
            push_hdr(hdr_idx);
            hdr_idx++;
         end else
            push_code(pick(q_cur, q_prev, ne_exp));
      end
      blank_prev = hb || vb;
      q_prev = q_cur;
      q_cur = quant(s, ql_exp);
      repeat (8) @(posedge clk_sys);
      sample_strobe <= 1'b0;
      repeat (40) @(posedge clk_sys);
   endtask

   task automatic line(input logic vert, input logic [7:0] fr, input int n_rand, input string name);
      fill_rate <= fr;
      repeat (2) sample(6'h3F, !vert, vert);
      repeat (10) sample(6'h3F, 1'b0, 1'b0);
      check(quant_level === ql_exp, "quantization level");
      v = 6'h20;
      if (vert)
         foreach (steps[i]) begin
            v = v + 6'(steps[i]);
            sample(v, 1'b0, 1'b0);
         end
      for (int i = 0; i < n_rand; i++) begin
         v = (i % 3 == 0) ? 6'($urandom) : v + 6'($urandom_range(8, 0)) - 6'h04;
         sample(v, 1'b0, 1'b0);
      end
      $display("test %s done", name);
   endtask

   // Every captured word outside reducer mode is compared with the predicted bit stream, first bit at the top
   always @(posedge clk_sys) begin
      if (got_word) begin
         words_seen++;
         if (red_mode)
            check(got_data === reducer_path_data, "reducer word");
         else begin
            for (int i = 29; i >= 0; i--)
               w[i] = exp_q.size() > 0 ? exp_q.pop_front() : 1'b0;
            check(got_data === w, "packed word");
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      $display("mismatch at %0t: run too long", $time);
      print_verdict();
   end

   initial begin
      {reset, wr_en, rd_en, sample_strobe, hblank, vblank, reducer_path_req} = 7'h01 << 6;
      {address, wr_data, video_in, reducer_path_data, fill_rate} = '0;
      {slow, drain, refill, ne_exp, blank_prev, vert_r, red_mode} = '0;
      {q_cur, q_prev, err_total, n_tests, words_seen} = '0;
      ql_exp = delta_stat_pkg::QL6;
      hdr_idx = 7;
      void'($urandom(32'h1edb4da4));
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check(mem_wr_req === 1'b0 && quant_level === delta_stat_pkg::QL6, "reset outputs");
      reg_rd(delta_stat_pkg::OFS_CTRL, rd_v);
      check(rd_v === 32'h0000_0001, "control reset");
      reg_rd(delta_stat_pkg::OFS_STATUS, rd_v);
      check(rd_v[2:0] === delta_stat_pkg::QL6, "status level");
      for (int i = 0; i < 8; i++) begin
         reg_rd(delta_stat_pkg::OFS_CODE + 8'(4 * i), rd_v);
         check(rd_v === {21'h0, delta_stat_pkg::CODE_TAB_RST[i]}, "code table");
      end
      reg_wr(delta_stat_pkg::OFS_THRESH, 32'h0000_A060);
      reg_rd(delta_stat_pkg::OFS_THRESH, rd_v);
      check(rd_v === 32'h0000_A060, "threshold write");
      reg_wr(delta_stat_pkg::OFS_THRESH, 32'h0000_9070);
      reg_wr(8'hFC, 32'hFFFF_FFFF);
      reg_rd(8'hFC, rd_v);
      check(rd_v === 32'h0, "unmapped read");
      $display("test registers done");
      line(1'b1, 8'h40, 30, "vertical line");
      slow <= 1'b1;
      line(1'b0, 8'h80, 30, "horizontal mid level");
      line(1'b0, 8'hC0, 30, "horizontal low level");
      drain <= 1'b1;
      repeat (100) @(posedge clk_sys);
      ne_exp = 1'b1;
      repeat (12) sample(6'($urandom), 1'b0, 1'b0);
      drain <= 1'b0;
      refill <= 1'b1;
      repeat (100) @(posedge clk_sys);
      refill <= 1'b0;
      ne_exp = 1'b0;
      $display("test nearly empty done");
      repeat (2) sample(6'h3F, 1'b0, 1'b0);
      slow <= 1'b0;
      reg_wr(delta_stat_pkg::OFS_CTRL, 32'h0000_0003);
      n0 = words_seen;
      repeat (24000) @(posedge clk_sys);
      reg_wr(delta_stat_pkg::OFS_CTRL, 32'h0000_0001);
      check(words_seen - n0 >= 19 && words_seen - n0 <= 21, "internal strobe rate");
      $display("test internal strobe done");
      repeat (100) @(posedge clk_sys);
      red_mode = 1'b1;
      reg_wr(delta_stat_pkg::OFS_CTRL, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         n0 = words_seen;
         @(posedge clk_sys);
         reducer_path_data <= 30'($urandom);
         reducer_path_req <= 1'b1;
         for (int k = 0; k < 50 && words_seen == n0; k++)
            @(posedge clk_sys);
         reducer_path_req <= 1'b0;
         check(words_seen == n0 + 1, "reducer request");
      end
      $display("test reducer path done");
      print_verdict();
   end
endmodule
`default_nettype wire
